// ==== core/iocrb_bank.sv ====
// IO configuration register bank: port A setup, misc system control and
// the digital side of the analog comparator.
// Assumes the core issues single-cycle rd/wr strobes on clk_sys; pins,
// comparator result and timer two clock are asynchronous.
//
// Operation
// - Bits 7:6 reset high; enable digital input and wake on pins 7,6
// - Bits 5,0 reset high; enable input, wake and interrupt pins 5,0
// - Bits 4:3 reset high; enable digital input and wake pins 4,3
// - Port data register, reset zero, holds output values
// - Direction register, reset zero; one makes a pin an output
// - Pull-up register, reset zero; one turns pull-up on
// - Pull-down register, reset zero; one turns pull-down on
// - Misc bit 5 picks wake delay: 16 or 8 slow clocks
// - Fast wake delay never applied while external oscillator runs
// - Misc bit 2 set disables low voltage reset
// - Misc bits 1:0 pick watchdog timeout 8k,16k,64k,256k
// - Control bit 7 enables comparator; software disables pin inputs
// - Read-only bit 6 shows comparator result
// - Bit 5 samples comparator output on timer two clock
// - Bit 4 inverts comparator output polarity
// - Bits 3:1 pick comparator minus input
// - Bit 0 picks comparator plus input: ladder or pin 4
// - Select bit 7 drives comparator output onto pin 0
// - Select bit 6 lets result level change wake the device
// - Select bits 5,4 pick range; bits 3:0 pick level
// - Pin 0/5 interrupt edge: both, rising or falling
// - Comparator request flag set by hardware, cleared by software
`default_nettype none
module iocrb_bank
  import iocrb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Core IO bus
  input wire iocrb_bus_t io_req,
  output logic [7:0] io_rdata,
  // Port A pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pull_up_en,
  output logic [7:0] pull_down_en,
  output logic [7:0] dig_in_en,
  // System control
  input wire logic external_osc_en,
  input wire logic [1:0] pin_irq_edge,
  input wire logic [1:0] cmp_irq_edge,
  input wire logic cmp_irq_clr,
  output logic wake_req,
  output logic [4:0] wake_low_speed_rc_osc_clks,
  output logic low_voltage_reset_dis,
  output logic [18:0] wdt_period,
  output logic pin_irq_event,
  output logic cmp_irq_pending,
  // Comparator
  input wire logic cmp_raw,
  input wire logic timer_two_clock,
  output iocrb_cmp_cfg_t cmp_cfg,
  output logic cmp_result_out
);
  logic [7:0] in_wake_en_ff;
  logic [7:0] port_data_ff;
  logic [7:0] port_dir_ff;
  logic [7:0] pull_up_ff;
  logic [7:0] pull_down_ff;
  logic [7:0] misc_ff;
  logic [6:0] cmp_ctrl_ff;
  logic [7:0] cmp_sel_ff;
  logic [9:0] sync_q;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev_ff;
  logic cmp_sync;
  logic cmp_res;
  logic cmp_res_prev_ff;
  logic tm2_sync;
  logic tm2_prev_ff;
  logic tm2_rise;
  logic cmp_change;
  logic cmp_event;
  logic [7:0] pin_toggle;
  logic pin_irq_hit;
  logic [7:0] port_read;
  logic [7:0] nxt_rdata;
  logic route_pin0;

  // Edge qualifier shared by pin and comparator requests
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic [1:0] code);
    logic hit;
    hit = 1'b0;
    unique case (code)
      EDGE_BOTH: hit = prev ^ cur;
      EDGE_RISE: hit = !prev && cur;
      EDGE_FALL: hit = prev && !cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  function automatic logic wr_to(input iocrb_bus_t req,
                                 input logic [5:0] addr);
    return req.wr && (req.addr == addr);
  endfunction : wr_to

  // Pins, comparator and timer clock all come from outside clk_sys
  iocrb_sync #(.W(10)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d_in({timer_two_clock, cmp_raw, pin_in}),
    .q_out(sync_q)
  );

  assign pin_sync = sync_q[7:0] & dig_in_en;
  assign cmp_sync = sync_q[8];
  assign tm2_sync = sync_q[9];
  assign tm2_rise = tm2_sync && !tm2_prev_ff;
  assign cmp_res = cmp_sync && cmp_ctrl_ff[CMP_RES_BIT];

  // Write-only input/wake enables; reserved bits never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_wake_en_ff <= RST_IN_WAKE_EN;
    end else if (wr_to(io_req, ADDR_IN_WAKE_EN)) begin
      in_wake_en_ff <= io_req.wdata & WAKE_PIN_MASK;
    end
  end

  // Pins 2 and 1 have no enable and stay readable
  assign dig_in_en = in_wake_en_ff | ~WAKE_PIN_MASK;

  // Port data, direction and pulls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_data_ff <= RST_PORT;
      port_dir_ff <= RST_PORT;
      pull_up_ff <= RST_PORT;
      pull_down_ff <= RST_PORT;
    end else begin
      if (wr_to(io_req, ADDR_PORT_DATA)) begin
        port_data_ff <= io_req.wdata;
      end
      if (wr_to(io_req, ADDR_PORT_DIR)) begin
        port_dir_ff <= io_req.wdata;
      end
      if (wr_to(io_req, ADDR_PULL_UP)) begin
        pull_up_ff <= io_req.wdata;
      end
      if (wr_to(io_req, ADDR_PULL_DOWN)) begin
        pull_down_ff <= io_req.wdata;
      end
    end
  end

  // Misc register; reserved bits dropped, they read nothing anyway
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misc_ff <= RST_MISC;
    end else if (wr_to(io_req, ADDR_MISC)) begin
      misc_ff <= io_req.wdata & 8'h27;
    end
  end

  // Comparator control; enable kept in the slot of the live result bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_ctrl_ff <= RST_CMP_CTRL;
      cmp_sel_ff <= RST_CMP_SEL;
    end else begin
      if (wr_to(io_req, ADDR_CMP_CTRL)) begin
        cmp_ctrl_ff <= {io_req.wdata[CMP_EN_BIT], io_req.wdata[5:0]};
      end
      if (wr_to(io_req, ADDR_CMP_SEL)) begin
        cmp_sel_ff <= io_req.wdata;
      end
    end
  end

  // Analog configuration out to the comparator macro
  assign cmp_cfg.en = cmp_ctrl_ff[CMP_RES_BIT];
  assign cmp_cfg.minus_sel = cmp_ctrl_ff[CMP_MINUS_LSB +: 3];
  assign cmp_cfg.plus_sel = cmp_ctrl_ff[CMP_PLUS_BIT];
  assign cmp_cfg.range_hi = cmp_sel_ff[SEL_RANGE_HI];
  assign cmp_cfg.range_lo = cmp_sel_ff[SEL_RANGE_LO];
  assign cmp_cfg.level = cmp_sel_ff[3:0];

  // System control; fast wake refused under the external oscillator
  assign wake_low_speed_rc_osc_clks = (misc_ff[MISC_FAST_WAKE] && !external_osc_en) ?
                          WAKE_FAST_CLKS : WAKE_SLOW_CLKS;
  assign low_voltage_reset_dis = misc_ff[MISC_LVR_DIS];

  // Watchdog timeout lookup
  always_comb begin
    unique case (misc_ff[MISC_WDT_LSB +: 2])
      2'h0: wdt_period = WDT_8K;
      2'h1: wdt_period = WDT_16K;
      2'h2: wdt_period = WDT_64K;
      2'h3: wdt_period = WDT_256K;
    endcase
  end

  // History for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_ff <= 8'h00;
      cmp_res_prev_ff <= 1'b0;
      tm2_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_sync;
      cmp_res_prev_ff <= cmp_res;
      tm2_prev_ff <= tm2_sync;
    end
  end

  // Comparator output: optionally inverted, optionally held between tm2 rising edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_result_out <= 1'b0;
    end else if (!cmp_ctrl_ff[CMP_SAMPLE_BIT] || tm2_rise) begin
      cmp_result_out <= cmp_res ^ cmp_ctrl_ff[CMP_INV_BIT];
    end
  end

  // Disabled pins read zero, so they cannot toggle
  assign pin_toggle = (pin_sync ^ pin_prev_ff) & in_wake_en_ff;
  assign cmp_change = cmp_res ^ cmp_res_prev_ff;
  assign cmp_event = edge_hit(cmp_res_prev_ff, cmp_res, cmp_irq_edge);
  assign pin_irq_hit =
    (in_wake_en_ff[PIN_IRQ_A] &&
     edge_hit(pin_prev_ff[PIN_IRQ_A], pin_sync[PIN_IRQ_A], pin_irq_edge)) ||
    (in_wake_en_ff[PIN_IRQ_B] &&
     edge_hit(pin_prev_ff[PIN_IRQ_B], pin_sync[PIN_IRQ_B], pin_irq_edge));

  // Wake and interrupt pulses, one cycle each
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
      pin_irq_event <= 1'b0;
    end else begin
      wake_req <= (|pin_toggle) ||
                  (cmp_sel_ff[SEL_WAKE] && cmp_change);
      pin_irq_event <= pin_irq_hit;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_irq_pending <= 1'b0;
    end else if (cmp_event) begin
      cmp_irq_pending <= 1'b1;
    end else if (cmp_irq_clr) begin
      cmp_irq_pending <= 1'b0;
    end
  end

  // Pin drive; routing forces pin 0 to an output
  assign route_pin0 = cmp_sel_ff[SEL_OUT_PIN0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pull_up_en <= 8'h00;
      pull_down_en <= 8'h00;
    end else begin
      pin_out <= {port_data_ff[7:1],
                  route_pin0 ? cmp_result_out : port_data_ff[0]};
      pin_oe <= port_dir_ff | {7'h00, route_pin0};
      pull_up_en <= pull_up_ff;
      pull_down_en <= pull_down_ff;
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  assign port_read = (port_dir_ff & port_data_ff) |
                     (~port_dir_ff & pin_sync);
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (io_req.addr)
      ADDR_PORT_DATA: nxt_rdata = port_read;
      ADDR_PORT_DIR: nxt_rdata = port_dir_ff;
      ADDR_PULL_UP: nxt_rdata = pull_up_ff;
      ADDR_PULL_DOWN: nxt_rdata = pull_down_ff;
      ADDR_CMP_CTRL: nxt_rdata = {cmp_ctrl_ff[CMP_RES_BIT], cmp_res,
                                  cmp_ctrl_ff[5:0]};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= io_req.rd ? nxt_rdata : 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence wr_seq(logic [5:0] a);
    io_req.wr && io_req.addr == a;
  endsequence

  sequence quiet_seq;
    in_wake_en_ff == 8'h00 && !cmp_sel_ff[SEL_WAKE];
  endsequence

  port_data_wr_a: assert property (
    wr_seq(ADDR_PORT_DATA) |=> port_data_ff == $past(io_req.wdata))
    else $error("port data write lost");

  dir_to_oe_a: assert property (
    wr_to(io_req, ADDR_PORT_DIR) && !route_pin0 ##1 !route_pin0
    |=> pin_oe == $past(io_req.wdata, 2))
    else $error("direction not on output enables");

  pull_up_a: assert property (
    wr_seq(ADDR_PULL_UP) |=> ##1 pull_up_en == $past(io_req.wdata, 2))
    else $error("pull-up enable wrong");

  pull_down_a: assert property (
    wr_seq(ADDR_PULL_DOWN) |=> ##1 pull_down_en == $past(io_req.wdata, 2))
    else $error("pull-down enable wrong");

  fast_wake_a: assert property (
    external_osc_en |-> wake_low_speed_rc_osc_clks == WAKE_SLOW_CLKS)
    else $error("fast wake under external oscillator");

  wake_delay_a: assert property (
    wr_seq(ADDR_MISC) ##1 !external_osc_en
    |-> wake_low_speed_rc_osc_clks == ($past(io_req.wdata[5]) ? 5'h08 : 5'h10))
    else $error("wake delay select wrong");

  wdt_long_a: assert property (
    wr_to(io_req, ADDR_MISC) && io_req.wdata[1:0] == 2'h3
    |=> wdt_period == 19'h40000)
    else $error("watchdog timeout wrong");

  port_read_a: assert property (
    io_req.rd && io_req.addr == ADDR_PORT_DATA
    |=> io_rdata == (($past(port_dir_ff) & $past(port_data_ff)) |
                     (~$past(port_dir_ff) & $past(pin_sync))))
    else $error("port read value wrong");

  wo_read_zero_a: assert property (
    io_req.rd && io_req.addr == ADDR_MISC |=> io_rdata == 8'h00)
    else $error("write-only register readable");

  irq_set_wins_a: assert property (
    cmp_event && cmp_irq_clr |=> cmp_irq_pending)
    else $error("comparator request lost on clear");

  quiet_wake_a: assert property (
    quiet_seq ##1 quiet_seq |=> !wake_req)
    else $error("wake with all sources off");

  route_pin0_a: assert property (
    route_pin0 ##1 route_pin0 |-> pin_oe[0] && pin_out[0] ==
                                  $past(cmp_result_out))
    else $error("comparator not routed to pin 0");
endmodule : iocrb_bank
`default_nettype wire

// ==== pkg/iocrb_pkg.sv ====
// Package for the IO configuration register bank: addresses, reset
// values, field positions, counts and the carrier structs.
// Assumes a core-side IO bus with 6-bit addresses and 8-bit data.
`default_nettype none
package iocrb_pkg;
  // IO addresses
  localparam logic [5:0] ADDR_IN_WAKE_EN = 6'h0d;
  localparam logic [5:0] ADDR_PORT_DATA = 6'h10;
  localparam logic [5:0] ADDR_PORT_DIR = 6'h11;
  localparam logic [5:0] ADDR_PULL_UP = 6'h12;
  localparam logic [5:0] ADDR_PULL_DOWN = 6'h13;
  localparam logic [5:0] ADDR_CMP_CTRL = 6'h1a;
  localparam logic [5:0] ADDR_MISC = 6'h1b;
  localparam logic [5:0] ADDR_CMP_SEL = 6'h1e;
  // Reset values
  localparam logic [7:0] RST_IN_WAKE_EN = 8'hf9;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [6:0] RST_CMP_CTRL = 7'h00;
  localparam logic [7:0] RST_CMP_SEL = 8'h00;
  // Pins with a real enable bit; pins 2 and 1 have none
  localparam logic [7:0] WAKE_PIN_MASK = 8'hf9;
  localparam int PIN_IRQ_A = 0;
  localparam int PIN_IRQ_B = 5;
  // Miscellaneous register fields
  localparam int MISC_FAST_WAKE = 5;
  localparam int MISC_LVR_DIS = 2;
  localparam int MISC_WDT_LSB = 0;
  // Comparator control fields
  localparam int CMP_EN_BIT = 7;
  localparam int CMP_RES_BIT = 6;
  localparam int CMP_SAMPLE_BIT = 5;
  localparam int CMP_INV_BIT = 4;
  localparam int CMP_MINUS_LSB = 1;
  localparam int CMP_PLUS_BIT = 0;
  // Comparator select fields
  localparam int SEL_OUT_PIN0 = 7;
  localparam int SEL_WAKE = 6;
  localparam int SEL_RANGE_HI = 5;
  localparam int SEL_RANGE_LO = 4;
  // Minus input codes; others are reserved
  localparam logic [2:0] MINUS_PIN3 = 3'h0;
  localparam logic [2:0] MINUS_PIN4 = 3'h1;
  localparam logic [2:0] MINUS_BANDGAP = 3'h2;
  localparam logic [2:0] MINUS_LADDER = 3'h3;
  localparam logic [2:0] MINUS_PIN6 = 3'h4;
  // Wake-up delay in low-speed RC clocks
  localparam logic [4:0] WAKE_SLOW_CLKS = 5'h10;
  localparam logic [4:0] WAKE_FAST_CLKS = 5'h08;
  // Watchdog timeout in low-speed RC clock periods
  localparam logic [18:0] WDT_8K = 19'h02000;
  localparam logic [18:0] WDT_16K = 19'h04000;
  localparam logic [18:0] WDT_64K = 19'h10000;
  localparam logic [18:0] WDT_256K = 19'h40000;
  // Edge select codes
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } iocrb_bus_t;

  typedef struct packed {
    logic en;
    logic [2:0] minus_sel;
    logic plus_sel;
    logic range_hi;
    logic range_lo;
    logic [3:0] level;
  } iocrb_cmp_cfg_t;
endpackage : iocrb_pkg
`default_nettype wire

// ==== core/iocrb_sync.sv ====
// Two-stage synchroniser for a vector of unrelated asynchronous levels.
// Assumes each bit is a slow level; no bus coherence is implied.
`default_nettype none
module iocrb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_out <= '0;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end
endmodule : iocrb_sync
`default_nettype wire

// ==== bench/iocrb_bank_test.sv ====
// Self-checking testbench for the IO configuration register bank.
// Assumes the bank stands alone; the bench drives every port itself.
`default_nettype none
module iocrb_bank_test
  import iocrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Design inputs, all given a value at time zero
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  iocrb_bus_t io_req = '0;
  logic [7:0] pin_in = 8'h00;
  logic external_osc_en = 1'b0;
  logic [1:0] pin_irq_edge = 2'h0;
  logic [1:0] cmp_irq_edge = 2'h0;
  logic cmp_irq_clr = 1'b0;
  logic cmp_raw = 1'b0;
  logic timer_two_clock = 1'b0;
  // Design outputs
  logic [7:0] io_rdata, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [7:0] dig_in_en;
  logic wake_req, low_voltage_reset_dis, pin_irq_event;
  logic cmp_irq_pending, cmp_result_out;
  logic [4:0] wake_low_speed_rc_osc_clks;
  logic [18:0] wdt_period;
  iocrb_cmp_cfg_t cmp_cfg;
  // Score keeping
  int n_errors = 0;
  int total_checks = 0;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  iocrb_bank dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .dig_in_en(dig_in_en),
    .external_osc_en(external_osc_en), .pin_irq_edge(pin_irq_edge),
    .cmp_irq_edge(cmp_irq_edge), .cmp_irq_clr(cmp_irq_clr),
    .wake_req(wake_req), .wake_low_speed_rc_osc_clks(wake_low_speed_rc_osc_clks),
    .low_voltage_reset_dis(low_voltage_reset_dis),
    .wdt_period(wdt_period), .pin_irq_event(pin_irq_event),
    .cmp_irq_pending(cmp_irq_pending), .cmp_raw(cmp_raw),
    .timer_two_clock(timer_two_clock), .cmp_cfg(cmp_cfg),
    .cmp_result_out(cmp_result_out)
  );

  // Final verdict; the only place the run ends
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Four-state compare so an unknown never counts as a match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Step n edges, then land 1 ns after so inputs never race the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Bus write; an idle cycle follows so strobes never retoggle in a step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick(1);
    io_req = '0;
    tick(1);
  endtask : wr

  // Bus read; data is registered at the taking edge
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    tick(1);
    d = io_rdata;
    io_req = '0;
    tick(1);
    check(32'(d), 32'(exp));
  endtask : rdchk

  // Count wake and pin interrupt pulses over a window of n cycles
  task automatic events(input int n, output int nw, output int ni);
    nw = 0;
    ni = 0;
    repeat (n) begin
      tick(1);
      if (wake_req === 1'b1) nw++;
      if (pin_irq_event === 1'b1) ni++;
    end
  endtask : events

  task automatic test_reset;
    check(32'(dig_in_en), 32'h000000ff);
    check(32'(wake_low_speed_rc_osc_clks), 32'd16);
    check(32'(wdt_period), 32'd8192);
    check(32'(low_voltage_reset_dis), 32'h0);
    check(32'({pin_oe, pull_up_en, pull_down_en}), 32'h0);
    check(32'(cmp_cfg), 32'h0);
    rdchk(ADDR_PORT_DATA, 8'h00);
    rdchk(ADDR_PORT_DIR, 8'h00);
    rdchk(ADDR_PULL_UP, 8'h00);
    rdchk(ADDR_PULL_DOWN, 8'h00);
    rdchk(ADDR_CMP_CTRL, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_port;
    wr(ADDR_PORT_DIR, 8'hf0);
    wr(ADDR_PORT_DATA, 8'ha5);
    wr(ADDR_PULL_UP, 8'h3c);
    wr(ADDR_PULL_DOWN, 8'hc3);
    pin_in = 8'h5a;
    tick(4);
    check(32'(pin_oe), 32'h000000f0);
    check(32'(pin_out & pin_oe), 32'h000000a0);
    check(32'(pull_up_en), 32'h0000003c);
    check(32'(pull_down_en), 32'h000000c3);
    rdchk(ADDR_PORT_DIR, 8'hf0);
    rdchk(ADDR_PULL_UP, 8'h3c);
    rdchk(ADDR_PULL_DOWN, 8'hc3);
    rdchk(ADDR_PORT_DATA, 8'haa);
    // Unmapped place: write ignored, read gives zero
    wr(6'h3f, 8'hff);
    rdchk(6'h3f, 8'h00);
    rdchk(ADDR_IN_WAKE_EN, 8'h00);
    wr(ADDR_PORT_DIR, 8'h00);
    pin_in = 8'h00;
    tick(4);
    $display("test_port done");
  endtask : test_port

  task automatic test_enable;
    int pins[4] = '{7, 6, 4, 3};
    int nw, ni;
    wr(ADDR_IN_WAKE_EN, 8'h00);
    pin_in = 8'hff;
    tick(4);
    check(32'(dig_in_en), 32'h00000006);
    rdchk(ADDR_PORT_DATA, 8'h06);
    // Pins must be low again before re-enabling, or the unmask is an edge
    pin_in = 8'h00;
    tick(4);
    foreach (pins[i]) for (int e = 0; e < 2; e++) begin
      wr(ADDR_IN_WAKE_EN, e ? 8'hf9 : 8'h00);
      pin_in = 8'h01 << pins[i];
      events(8, nw, ni);
      check(32'(nw), 32'(e));
      pin_in = 8'h00;
      events(8, nw, ni);
    end
    $display("test_enable done");
  endtask : test_enable

  task automatic test_irq;
    int irqp[2] = '{0, 5};
    int nw, ni;
    // Code 3 is reserved and must trigger no interrupt
    for (int c = 0; c < 4; c++) foreach (irqp[i]) begin
      pin_irq_edge = 2'(c);
      wr(ADDR_IN_WAKE_EN, 8'hf9);
      pin_in = 8'h01 << irqp[i];
      events(8, nw, ni);
      check(32'(ni), 32'(c < 2));
      check(32'(nw), 32'h1);
      pin_in = 8'h00;
      events(8, nw, ni);
      check(32'(ni), 32'(!c[0]));
      // Disabled pin: neither wake nor interrupt
      wr(ADDR_IN_WAKE_EN, 8'h00);
      pin_in = 8'h01 << irqp[i];
      events(8, nw, ni);
      check(32'({nw[3:0], ni[3:0]}), 32'h0);
      pin_in = 8'h00;
      tick(4);
    end
    wr(ADDR_IN_WAKE_EN, 8'hf9);
    $display("test_irq done");
  endtask : test_irq

  task automatic test_misc;
    logic [18:0] wdt[4] = '{WDT_8K, WDT_16K, WDT_64K, WDT_256K};
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MISC, 8'(c));
      check(32'(wdt_period), 32'(wdt[c]));
    end
    wr(ADDR_MISC, 8'h24);
    check(32'(wake_low_speed_rc_osc_clks), 32'd8);
    check(32'(low_voltage_reset_dis), 32'h1);
    external_osc_en = 1'b1;
    tick(1);
    check(32'(wake_low_speed_rc_osc_clks), 32'd16);
    external_osc_en = 1'b0;
    // Reserved bits set must not leak into any field
    wr(ADDR_MISC, 8'hdb);
    check(32'({wake_low_speed_rc_osc_clks, low_voltage_reset_dis}), 32'd32);
    check(32'(wdt_period), 32'(WDT_256K));
    rdchk(ADDR_MISC, 8'h00);
    wr(ADDR_MISC, 8'h00);
    $display("test_misc done");
  endtask : test_misc

  task automatic test_cmp;
    int nw, ni;
    cmp_raw = 1'b1;
    wr(ADDR_CMP_SEL, 8'hbc);
    wr(ADDR_CMP_CTRL, 8'h95);
    tick(4);
    check(32'(cmp_cfg), 32'({1'b1, MINUS_BANDGAP, 3'h7, 4'hc}));
    rdchk(ADDR_CMP_CTRL, 8'hd5);
    check(32'(cmp_result_out), 32'h0);
    check(32'({pin_oe[0], pin_out[0]}), 32'h2);
    rdchk(ADDR_CMP_SEL, 8'h00);
    cmp_raw = 1'b0;
    wr(ADDR_CMP_CTRL, 8'hd5);
    tick(4);
    rdchk(ADDR_CMP_CTRL, 8'h95);
    check(32'({cmp_result_out, pin_out[0]}), 32'h3);
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_CMP_CTRL, {4'h8, 3'(c), 1'b0});
      check(32'(cmp_cfg.minus_sel), 32'(c));
      check(32'(cmp_cfg.plus_sel), 32'h0);
    end
    tick(2);
    check(32'(cmp_result_out), 32'h0);
    // Sampled mode holds the output until the timer clock rises
    wr(ADDR_CMP_CTRL, 8'ha0);
    cmp_raw = 1'b1;
    tick(6);
    check(32'(cmp_result_out), 32'h0);
    timer_two_clock = 1'b1;
    tick(6);
    check(32'(cmp_result_out), 32'h1);
    timer_two_clock = 1'b0;
    // Comparator wake and sticky request flag
    cmp_irq_edge = EDGE_RISE;
    wr(ADDR_CMP_SEL, 8'h40);
    wr(ADDR_CMP_CTRL, 8'h80);
    cmp_raw = 1'b0;
    tick(6);
    cmp_irq_clr = 1'b1;
    tick(1);
    cmp_irq_clr = 1'b0;
    tick(1);
    check(32'(cmp_irq_pending), 32'h0);
    cmp_raw = 1'b1;
    events(8, nw, ni);
    check(32'(nw), 32'h1);
    check(32'(cmp_irq_pending), 32'h1);
    cmp_raw = 1'b0;
    events(8, nw, ni);
    check(32'({nw[3:0], cmp_irq_pending}), 32'h3);
    cmp_irq_clr = 1'b1;
    tick(1);
    cmp_irq_clr = 1'b0;
    tick(1);
    check(32'(cmp_irq_pending), 32'h0);
    // Clear lands on the edge the rise is seen: the set must win
    wr(ADDR_CMP_SEL, 8'h00);
    cmp_raw = 1'b1;
    tick(2);
    cmp_irq_clr = 1'b1;
    tick(1);
    cmp_irq_clr = 1'b0;
    check(32'({cmp_irq_pending, wake_req}), 32'h2);
    events(8, nw, ni);
    check(32'(nw), 32'h0);
    $display("test_cmp done");
  endtask : test_cmp

  // Main sequence
  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(1);
    test_reset;
    test_port;
    test_enable;
    test_irq;
    test_misc;
    test_cmp;
    summarize;
  end

  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    n_errors++;
    $display("ERROR %0t: run timed out", $time);
    summarize;
  end
endmodule : iocrb_bank_test
`default_nettype wire
